// ---- dv/epdsq_monitor.sv ----
// Port checker for the EPD serial pixel sequencer
`timescale 1ns/1ps
`default_nettype none
module epdsq_monitor
	import epdsq_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic go_write_in,
	input wire logic go_value_in,
	input wire logic done_clear_in,
	input wire logic update_go_bit_out,
	input wire logic update_done_flag_out,
	input wire epdsq_mem_s mem_req_out,
	input wire logic scl_out,
	input wire logic cs_n_out,
	input wire logic dc_out,
	input wire logic sda_out,
	input wire logic sda_oe_out
);
	// One clock domain, so clock and reset are given once
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// A start that the block must accept
	wire logic take = go_write_in && go_value_in && !update_go_bit_out;
	go_take_a: assert property (take |=> update_go_bit_out ##1 !cs_n_out)
		else $error("start not taken");
	go_hold_a: assert property (!take && !update_go_bit_out |=> !update_go_bit_out)
		else $error("go bit rose without start");
	done_set_a: assert property ($fell(update_go_bit_out) |-> update_done_flag_out)
		else $error("done flag missing at finish");
	done_keep_a: assert property (update_done_flag_out && !done_clear_in |=> update_done_flag_out)
		else $error("done flag lost");
	scl_idle_a: assert property (cs_n_out |-> scl_out == SCL_IDLE)
		else $error("link clock moved while deselected");
	dc_cmd_a: assert property ($fell(cs_n_out) |-> dc_out == DC_COMMAND)
		else $error("first byte not marked command");
	sda_hold_a: assert property ($rose(scl_out) |-> $stable(sda_out))
		else $error("data moved at clock rise");
	scl_high_a: assert property ($rose(scl_out) |=> scl_out [*3] ##1 !scl_out)
		else $error("link clock high time wrong");
	mem_wr_a: assert property (mem_req_out.wr |-> update_go_bit_out && !mem_req_out.rd)
		else $error("store outside a transfer");
	oe_idle_a: assert property (cs_n_out |-> !sda_oe_out)
		else $error("data pin driven while deselected");
endmodule
bind epdsq_sequencer epdsq_monitor u_mon (.clk_in(clk_in), .nrst_in(nrst_in),
	.go_write_in(go_write_in), .go_value_in(go_value_in),
	.done_clear_in(done_clear_in), .update_go_bit_out(update_go_bit_out),
	.update_done_flag_out(update_done_flag_out), .mem_req_out(mem_req_out),
	.scl_out(scl_out), .cs_n_out(cs_n_out), .dc_out(dc_out), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out));
`default_nettype wire

// ---- dv/epdsq_panel_model.sv ----
// Behavioural panel on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none
module epdsq_panel_model (
	input wire logic scl_in,
	input wire logic cs_n_in,
	input wire logic dc_in,
	input wire logic three_wire_in, // Indicator travels in-band first
	input wire logic sda_in,
	output logic sda_out
);
	logic [8:0] shift = 9'h000; // Last bit of a byte ends in bit 0
	int per = 8; // Bits that make one byte on the wire
	logic [7:0] ans; // Byte being answered in a read
	int n_bits = 0; // Clock rises seen in this frame
	logic [8:0] got[$]; // Indicator and byte, one per byte heard
	initial sda_out = 1'b0;
	// Gather a bit on each rise while selected
	always @(posedge scl_in) if (!cs_n_in) begin
		shift = {shift[7:0], sda_in};
		n_bits++;
		per = three_wire_in ? 9 : 8;
		if (n_bits % per == 0)
			got.push_back(three_wire_in ? shift : {dc_in, shift[7:0]});
	end
	// A new frame restarts the count
	always @(negedge cs_n_in) n_bits = 0;
	// Answer bytes shift out on falls; pattern is A5 xor byte number
	always @(negedge scl_in) if (!cs_n_in && n_bits >= 8) begin
		ans = 8'hA5 ^ 8'((n_bits - 8) / 8);
		sda_out = ans[7 - (n_bits - 8) % 8];
	end
	// Released line must not look like held data
	always @(posedge cs_n_in) sda_out = ~sda_out;
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the EPD serial pixel sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
	import epdsq_pkg::*;
	logic clk_in = 1'b0, nrst_in = 1'b0, done_clear_in = 1'b0;
	logic go_write_in = 1'b0, go_value_in = 1'b0, sda_in;
	epdsq_cfg_s cfg_in = '0;
	logic [15:0] base_addr_in = '0;
	logic [7:0] mem_rdata_in = '0;
	logic go_bit, done_flag, scl, cs_n, dc, sda, sda_oe;
	epdsq_mem_s mem_req;
	logic [7:0] mem [256]; // Frame memory behind the block
	int n_fail = 0, cmp_count = 0, cycles = 0;
	always #10 clk_in = ~clk_in;
	epdsq_sequencer u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
		.go_write_in(go_write_in), .go_value_in(go_value_in),
		.done_clear_in(done_clear_in), .cfg_in(cfg_in),
		.base_addr_in(base_addr_in), .mem_rdata_in(mem_rdata_in),
		.sda_in(sda_in), .update_go_bit_out(go_bit),
		.update_done_flag_out(done_flag), .mem_req_out(mem_req),
		.scl_out(scl), .cs_n_out(cs_n), .dc_out(dc), .sda_out(sda),
		.sda_oe_out(sda_oe));
	epdsq_panel_model u_panel (.scl_in(scl), .cs_n_in(cs_n), .dc_in(dc),
		.three_wire_in(cfg_in.three_wire), .sda_in(sda), .sda_out(sda_in));
	// Memory answers a read on the next cycle; stores land at once
	always @(posedge clk_in) begin
		if (mem_req.rd) mem_rdata_in <= #1 mem[mem_req.addr[7:0]];
		if (mem_req.wr) mem[mem_req.addr[7:0]] = mem_req.wdata;
	end
	// Hang guard, far above the fewer than two thousand cycles needed
	always @(posedge clk_in) if (++cycles == 20000) begin
		n_fail++;
		close_out();
	end
	// Expected slot order, slot seven in bit 7
	function automatic logic [7:0] smap(logic [1:0] dep, logic b, logic p,
		logic [7:0] d);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = d[7 - i];
		if (dep == DEPTH_1BPP) return p ? d : r;
		case ({b, p})
			2'h0: return r;
			2'h2: return {d[1], d[0], d[3], d[2], d[5], d[4], d[7], d[6]};
			2'h1: return {d[6], d[7], d[4], d[5], d[2], d[3], d[0], d[1]};
			default: return d;
		endcase
	endfunction
	task automatic pulse_go(input logic v);
		@(posedge clk_in);
		#1 go_write_in = 1'b1;
		go_value_in = v;
		@(posedge clk_in);
		#1 go_write_in = 1'b0;
	endtask
	// One transfer, with a refused second start while busy
	task automatic run(input epdsq_cfg_s c, input logic [15:0] base);
		int k;
		cfg_in = c;
		base_addr_in = base;
		pulse_go(1'b1);
		`CHK("go_bit", 1'b1, go_bit)
		pulse_go(1'b1);
		k = 0;
		while (go_bit === 1'b1 && k < 4000) begin
			@(posedge clk_in);
			#1 k++;
		end
		`CHK("done_flag", 1'b1, done_flag)
		`CHK("go_clear", 1'b0, go_bit)
		done_clear_in = 1'b1;
		@(posedge clk_in);
		#1 done_clear_in = 1'b0;
		`CHK("done_clear", 1'b0, done_flag)
	endtask
	task automatic t_refuse();
		pulse_go(1'b0);
		`CHK("go_zero", 1'b0, go_bit)
		$display("refuse test done");
	endtask
	task automatic t_write();
		epdsq_cfg_s c;
		logic [7:0] e;
		for (int m = 0; m < 7; m++) begin
			c = '0;
			c.direction = DIR_WRITE;
			c.three_wire = m == 6;
			c.command = 8'h3C + 8'(m);
			c.depth = m < 2 ? DEPTH_1BPP : DEPTH_2BPP;
			{c.bit_order, c.pixel_order} = m == 0 ? 2'h2 : m == 1 ? 2'h1 : 2'(m - 2);
			c.width = m < 2 ? 10'h8 : 10'h4;
			c.height = 10'h2;
			u_panel.got.delete();
			run(c, 16'h0010);
			`CHK("n_bytes", 3, u_panel.got.size())
			`CHK("cmd", {DC_COMMAND, c.command}, u_panel.got[0])
			for (int n = 0; n < 2; n++) begin
				e = smap(c.depth, c.bit_order, c.pixel_order, mem[8'h10 + n]);
				`CHK("data", {DC_DATA, e}, u_panel.got[n + 1])
			end
		end
		$display("write modes test done");
	endtask
	task automatic t_read();
		epdsq_cfg_s c;
		c = '0;
		c.direction = DIR_READ;
		c.bit_order = 1'b1;
		c.depth = DEPTH_8BPP;
		c.command = 8'h71;
		c.width = 10'h2;
		c.height = 10'h1;
		mem[8'h80] = 8'h00;
		mem[8'h81] = 8'h00;
		u_panel.got.delete();
		run(c, 16'h0080);
		`CHK("rd_cmd", {DC_COMMAND, 8'h71}, u_panel.got[0])
		`CHK("rd_byte0", 8'hA5, mem[8'h80])
		`CHK("rd_byte1", 8'hA4, mem[8'h81])
		$display("read test done");
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i * 8'h35 + 8'h1B);
		repeat (3) @(posedge clk_in);
		#1 nrst_in = 1'b1;
		t_refuse();
		t_write();
		t_read();
		close_out();
	end
endmodule
`default_nettype wire

// ---- rtl/epdsq_pkg.sv ----
// Shared constants and carrier types for the EPD serial pixel sequencer
package epdsq_pkg;
	// Pixel depth field codes (bits per pixel = 2^code)
	localparam logic [1:0] DEPTH_1BPP = 2'h0;
	localparam logic [1:0] DEPTH_2BPP = 2'h1;
	localparam logic [1:0] DEPTH_4BPP = 2'h2;
	localparam logic [1:0] DEPTH_8BPP = 2'h3;
	// Command/data indicator levels on the link
	localparam logic DC_COMMAND = 1'b0;
	localparam logic DC_DATA = 1'b1;
	// Direction select codes
	localparam logic DIR_READ = 1'b0;
	localparam logic DIR_WRITE = 1'b1;
	// Serial timing: link clock half period in system clocks
	localparam int CLK_HZ = 50000000;
	localparam int HALF_PERIOD_NS = 80;
	localparam int HALF_PERIOD_CYC = (HALF_PERIOD_NS * (CLK_HZ / 1000000)
		+ 999) / 1000;
	// Bits per byte slot on each wire variant
	localparam logic [3:0] BITS_4WIRE = 4'h8;
	localparam logic [3:0] BITS_3WIRE = 4'h9;
	// Reset values of link pins
	localparam logic CS_IDLE_N = 1'b1;
	localparam logic SCL_IDLE = 1'b0;
	// Transfer configuration carried as one group
	typedef struct packed {
		logic direction;   // 1 write, 0 read
		logic three_wire;  // 1 selects 3-wire variant
		logic bit_order;   // Bit order select
		logic pixel_order; // Pixel order select
		logic [1:0] depth; // Pixel depth field
		logic [7:0] command;
		logic [9:0] width;
		logic [9:0] height;
	} epdsq_cfg_s;
	// Frame memory request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} epdsq_mem_s;
endpackage

// ---- rtl/epdsq_sequencer.sv ----
// EPD serial pixel sequencer: command plus frame bytes over 3/4-wire link
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Finish clears go bit and sets done flag
// - Direction 0 stores panel bytes from base
// - Byte order from depth, orders, width, height
// - Command first, then ascending bytes, slot7 first
// - Byte n+1 is frame byte n, H lines
// - 1BPP low pixel first sends bits 0..7
// - 1BPP high pixel first sends bits 7..0
// - 2BPP B0 P0 sends 0..7
// - 2BPP B1 P0 sends 1,0,3,2,5,4,7,6
// - 2BPP B0 P1 sends 6,7,4,5,2,3,0,1
// - 2BPP B1 P1 sends 7..0
// - Direction 1 writes, 0 reads
// - Command indicator 0, data indicator 1
// - 3-wire bytes take nine clocks, indicator first
module epdsq_sequencer
	import epdsq_pkg::*;
#(
	parameter int ADDR_W = 16, // Frame memory address width
	parameter int HALF_CYC = HALF_PERIOD_CYC // Link half period, cycles
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic go_write_in,   // One-cycle software write strobe
	input wire logic go_value_in,   // Value written to update_go_bit
	input wire logic done_clear_in, // One-cycle clear of done flag
	input wire epdsq_cfg_s cfg_in,  // Transfer configuration
	input wire logic [ADDR_W-1:0] base_addr_in, // Buffer base address
	input wire logic [7:0] mem_rdata_in, // Read data, one cycle after rd
	input wire logic sda_in,        // Panel serial data input pin
	output logic update_go_bit_out,
	output logic update_done_flag_out,
	output epdsq_mem_s mem_req_out, // Frame memory request
	output logic scl_out,
	output logic cs_n_out,
	output logic dc_out,            // 4-wire indicator pin
	output logic sda_out,
	output logic sda_oe_out
);
	// Reject address widths and half periods the counters cannot hold
	if (ADDR_W < 1 || ADDR_W > 16 || HALF_CYC < 1 || HALF_CYC > 256)
		$error("epdsq_sequencer: unsupported parameter");

	typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_SHIFT,
		ST_STORE, ST_DONE} epdsq_state_e;
	epdsq_state_e state, next_state;

	epdsq_cfg_s cfg;          // Configuration latched at start
	logic [ADDR_W-1:0] addr;  // Current frame byte address
	logic [19:0] bytes_left;  // Data bytes still to move
	logic is_cmd;             // Current slot is the command byte
	logic [8:0] shreg;        // Outgoing bits, slot 8 (indicator) on top
	logic [7:0] rxreg;        // Bytes collected from the panel
	logic [3:0] bit_cnt;      // Bits left in current slot
	logic [7:0] half_cnt;     // Link clock timer
	logic phase;              // 0 low half, 1 high half of link clock
	logic [2:0] sda_sync;     // Pin input synchroniser
	logic rx_bit;             // Panel bit once two stages agree

	// Total data bytes from width, height and depth, width kept whole by software
	wire [19:0] total_bytes;
	wire [19:0] px_total = 20'(cfg_in.width) * 20'(cfg_in.height);
	assign total_bytes = px_total >> (3 - cfg_in.depth);

	// Reorder a frame byte into serial slots 7..0 per depth and orders
	wire [7:0] fb = mem_rdata_in;
	wire [7:0] rev = {fb[0], fb[1], fb[2], fb[3], fb[4], fb[5], fb[6], fb[7]};
	wire [7:0] pair_swap = {fb[1], fb[0], fb[3], fb[2], fb[5], fb[4],
		fb[7], fb[6]};
	wire [7:0] pair_rev = {fb[6], fb[7], fb[4], fb[5], fb[2], fb[3],
		fb[0], fb[1]};
	wire [7:0] nib_swap = {fb[3], fb[2], fb[1], fb[0], fb[7], fb[6],
		fb[5], fb[4]};
	wire [7:0] nib_rev = {fb[4], fb[5], fb[6], fb[7], fb[0], fb[1],
		fb[2], fb[3]};
	wire [1:0] ord = {cfg.bit_order, cfg.pixel_order};
	logic [7:0] slots; // Serial slots, index 7 leaves first
	always_comb begin
		case (cfg.depth)
			DEPTH_1BPP: slots = cfg.pixel_order ? fb : rev;
			DEPTH_2BPP: begin
				case (ord)
					2'h0: slots = rev;
					2'h2: slots = pair_swap;
					2'h1: slots = pair_rev;
					default: slots = fb;
				endcase
			end
			DEPTH_4BPP: begin
				case (ord)
					2'h0: slots = rev;
					2'h2: slots = nib_swap;
					2'h1: slots = nib_rev;
					default: slots = fb;
				endcase
			end
			default: slots = cfg.bit_order ? fb : rev;
		endcase
	end
	// Received bytes are stored through the inverse mapping
	logic [7:0] rx_fb;
	wire [7:0] r = rxreg;
	always_comb begin
		rx_fb = r;
		case (cfg.depth)
			DEPTH_1BPP: rx_fb = cfg.pixel_order ? r :
				{r[0], r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
			DEPTH_2BPP: begin
				case (ord)
					2'h0: rx_fb = {r[0], r[1], r[2], r[3], r[4], r[5],
						r[6], r[7]};
					2'h2: rx_fb = {r[1], r[0], r[3], r[2], r[5], r[4],
						r[7], r[6]};
					2'h1: rx_fb = {r[6], r[7], r[4], r[5], r[2], r[3],
						r[0], r[1]};
					default: rx_fb = r;
				endcase
			end
			DEPTH_4BPP: begin
				case (ord)
					2'h0: rx_fb = {r[0], r[1], r[2], r[3], r[4], r[5],
						r[6], r[7]};
					2'h2: rx_fb = {r[3], r[2], r[1], r[0], r[7], r[6],
						r[5], r[4]};
					2'h1: rx_fb = {r[4], r[5], r[6], r[7], r[0], r[1],
						r[2], r[3]};
					default: rx_fb = r;
				endcase
			end
			default: rx_fb = cfg.bit_order ? r :
				{r[0], r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
		endcase
	end

	// Control decodes
	wire start = go_write_in && go_value_in && state == ST_IDLE;
	wire tick = half_cnt == 8'(HALF_CYC - 1);
	// Panel drives on the fall, so its bit is taken just before the next fall
	wire fall = tick && phase;    // Link clock goes low, next bit shifts
	wire slot_end = fall && bit_cnt == 4'h1;
	wire reading = cfg.direction == DIR_READ && !is_cmd;
	wire [3:0] slot_bits = cfg.three_wire ? BITS_3WIRE : BITS_4WIRE;
	// The command slot counts no data; a data slot ends the frame at one
	wire last_slot = is_cmd ? bytes_left == 20'h0
		: bytes_left == 20'h1;
	// The indicator bit of a 3-wire read slot is not a payload bit
	wire rx_payload = !(cfg.three_wire && bit_cnt == BITS_3WIRE);

	// Next-state decode
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (start) next_state = ST_SHIFT;
			ST_FETCH: next_state = ST_WAIT;
			ST_WAIT: next_state = ST_SHIFT;
			ST_SHIFT: begin
				if (slot_end) begin
					if (reading)
						next_state = ST_STORE;
					else if (last_slot)
						next_state = ST_DONE;
					else if (cfg.direction == DIR_WRITE)
						next_state = ST_FETCH;
					else
						next_state = ST_SHIFT;
				end
			end
			ST_STORE: next_state = (bytes_left == 20'h0) ? ST_DONE
				: ST_SHIFT;
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Three-stage pin synchroniser; a level counts once stages two and
	// three agree, which needs a half period of at least three clocks
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sda_sync <= 3'h0;
			rx_bit <= 1'b0;
		end else begin
			sda_sync <= {sda_sync[1:0], sda_in};
			if (sda_sync[2] == sda_sync[1])
				rx_bit <= sda_sync[2];
		end
	end

	// Go bit and done flag; a new finish wins over a clear
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			update_go_bit_out <= 1'b0;
			update_done_flag_out <= 1'b0;
		end else begin
			if (start)
				update_go_bit_out <= 1'b1;
			else if (state == ST_DONE)
				update_go_bit_out <= 1'b0;
			if (state == ST_DONE)
				update_done_flag_out <= 1'b1;
			else if (done_clear_in)
				update_done_flag_out <= 1'b0;
		end
	end

	// Link clock timer runs only while a slot is shifting
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			half_cnt <= 8'h0;
			phase <= 1'b0;
		end else if (state != ST_SHIFT) begin
			half_cnt <= 8'h0;
			phase <= 1'b0;
		end else if (tick) begin
			half_cnt <= 8'h0;
			phase <= !phase;
		end else begin
			half_cnt <= half_cnt + 8'h1;
		end
	end

	// Transfer bookkeeping: latch, address walk, byte count
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg <= '0;
			addr <= '0;
			bytes_left <= 20'h0;
			is_cmd <= 1'b0;
		end else if (start) begin
			cfg <= cfg_in;
			addr <= base_addr_in;
			bytes_left <= total_bytes;
			is_cmd <= 1'b1;
		end else if (slot_end) begin
			is_cmd <= 1'b0;
			if (!is_cmd)
				bytes_left <= bytes_left - 20'h1;
		end else if (state == ST_STORE || state == ST_FETCH) begin
			// Step only after the request has taken the current address
			addr <= addr + 1'b1;
		end
	end

	// Shift path; slot 8 holds the indicator for the 3-wire variant
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			shreg <= 9'h0;
			bit_cnt <= 4'h0;
			rxreg <= 8'h0;
		end else if (start) begin
			shreg <= {DC_COMMAND, cfg_in.command};
			bit_cnt <= cfg_in.three_wire ? BITS_3WIRE : BITS_4WIRE;
		end else if (state == ST_WAIT) begin
			shreg <= {DC_DATA, slots};
			bit_cnt <= slot_bits;
		end else if (state == ST_STORE || (slot_end && !reading
			&& cfg.direction == DIR_READ)) begin
			shreg <= {DC_DATA, 8'h0};
			bit_cnt <= slot_bits;
		end else if (fall) begin
			// The 3-wire indicator leaves from slot 8 without a shift
			if (!(cfg.three_wire && bit_cnt == BITS_3WIRE))
				shreg <= {shreg[7:0], 1'b0};
			if (reading && rx_payload)
				rxreg <= {rxreg[6:0], rx_bit};
			bit_cnt <= bit_cnt - 4'h1;
		end
	end

	// Slot bit on the wire: indicator first on 3-wire, then slot 7 down
	wire out_bit = (cfg.three_wire && bit_cnt == BITS_3WIRE) ? shreg[8]
		: shreg[7];
	wire busy = state != ST_IDLE && state != ST_DONE;

	// Pin and memory registers
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			scl_out <= SCL_IDLE;
			cs_n_out <= CS_IDLE_N;
			dc_out <= DC_COMMAND;
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
			mem_req_out <= '0;
		end else begin
			scl_out <= state == ST_SHIFT && phase;
			cs_n_out <= !busy;
			dc_out <= is_cmd ? DC_COMMAND : DC_DATA;
			sda_out <= out_bit;
			sda_oe_out <= state == ST_SHIFT && (!reading ||
				(cfg.three_wire && bit_cnt == BITS_3WIRE));
			mem_req_out.rd <= next_state == ST_FETCH;
			mem_req_out.wr <= state == ST_STORE;
			mem_req_out.addr <= 16'(addr);
			mem_req_out.wdata <= rx_fb;
		end
	end
endmodule
`default_nettype wire
